// ===== shared/gate_ctrl_pkg.sv
package gate_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GATE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMER_ON = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions of the gate control register and the timer-on register
  // ----------------------------------------------------------------
  localparam int BIT_GATE_ENABLE = 7;
  localparam int BIT_GATE_POLARITY = 6;
  localparam int BIT_TOGGLE_MODE = 5;
  localparam int BIT_SINGLE_PULSE = 4;
  localparam int BIT_GO_DONE = 3;
  localparam int BIT_GATE_VALUE = 2;
  localparam int BIT_TIMER_ON = 0;

  // Status and mask fields
  localparam int EV_GATE_EDGE = 0;
  localparam int EV_PULSE_DONE = 1;
  localparam int EV_W = 2;

  // ----------------------------------------------------------------
  // Reset values and synchroniser depth
  // ----------------------------------------------------------------
  localparam logic [EV_W-1:0] STATUS_RESET = 2'h0;
  localparam logic [EV_W-1:0] MASK_RESET = 2'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  localparam int SYNC_STAGES = 2;

  // Writable control fields, carried together
  typedef struct packed {
    logic gate_enable;
    logic gate_polarity;
    logic gate_toggle_mode;
    logic gate_single_pulse_mode;
  } gate_cfg_s;

  localparam gate_cfg_s CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

  // Single-pulse acquisition, Gray coded along idle->armed->acquire
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_ARMED = 2'b01,
    SP_ACQUIRE = 2'b11
  } pulse_state_e;

endpackage : gate_ctrl_pkg

// ===== hdl/level_sync.sv
`timescale 1ns/100ps
module level_sync #(
  parameter int STAGES = 2
) (
  input wire logic pclk,     // System clock
  input wire logic presetn,  // Async reset, active low
  input wire logic async_in, // Level from another domain
  output logic sync_out      // Level in pclk domain
);

  logic [STAGES-1:0] chain_r;
  logic [STAGES-1:0] chain_nxt;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  initial begin
    if (STAGES < 2) begin
      $error("level_sync needs at least two stages");
    end
  end

  // Shift the level along the chain
  always_comb begin
    chain_nxt = {chain_r[STAGES-2:0], async_in};
  end

  // Chain registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_r <= '0;
    end else begin
      chain_r <= chain_nxt;
    end
  end

  assign sync_out = chain_r[STAGES-1];

endmodule : level_sync

// ===== hdl/timer_gate_control.sv
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
// Notes on behaviour
// [RL1] In toggle mode the gate flip-flop flips on each rising gate edge, else it is held clear.
// [RL2] The single-pulse mode bit turns single-pulse acquisition on, and clearing it restores normal gating.
// [RL3] The go/done bit reads one while an acquisition is armed and waiting for a gate edge.
// [RL4] The go/done bit reads zero when no acquisition runs, and hardware clears it at completion.
// [RL5] Clearing the single-pulse mode bit also clears the go/done bit.
// [RL6] The read-only gate value bit shows the gate that could reach the counter, whatever the enable.
// [RL7] Turning the timer off stops it and clears the gate flip-flop.
// [RL8] With the timer on and gating enabled the count runs only while the gate is at its active level, or while the gate flip-flop is set in toggle mode.
module timer_gate_control
  import gate_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,            // System clock
  input wire logic presetn,         // Async reset, active low
  input wire logic psel,            // APB select
  input wire logic penable,         // APB access phase
  input wire logic pwrite,          // APB write
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata,   // APB write data
  output logic [31:0] prdata,       // APB read data
  output logic pready,              // APB ready
  output logic pslverr,             // APB error, unmapped address
  input wire logic gate_in,         // Selected gate source, async
  output logic count_enable,        // Counter may advance
  output logic gate_flop,           // Gate toggle flip-flop
  output logic irq                  // Level interrupt
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  initial begin
    if (ADDR_W < 4) begin
      $error("timer_gate_control needs at least 4 address bits");
    end
    if (SYNC_STAGES < 2) begin
      $error("timer_gate_control needs two synchroniser stages");
    end
    if (EV_W > 8) begin
      $error("timer_gate_control status exceeds one byte");
    end
    if (BIT_GATE_ENABLE > 7) begin
      $error("timer_gate_control fields exceed one byte");
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  gate_cfg_s cfg_r, cfg_nxt;
  pulse_state_e sp_r, sp_nxt;
  logic timer_on_r, timer_on_nxt;
  logic toggle_r, toggle_nxt;
  logic lvl_prev_r, lvl_prev_nxt;
  logic src_prev_r, src_prev_nxt;
  logic count_r, count_nxt;
  logic irq_r, irq_nxt;
  logic [EV_W-1:0] status_r, status_nxt;
  logic [EV_W-1:0] mask_r, mask_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  logic gate_sync;
  logic gate_level;
  logic gate_src;
  logic gate_value;
  logic lvl_rise;
  logic src_rise;
  logic src_fall;
  logic pulse_done;
  logic access;
  logic done_xfer;
  logic wr_ctrl;
  logic arm_req;
  logic wr_timer_on;
  logic wr_mask;
  logic rd_status;
  logic acquiring;
  logic go_done;
  logic [7:0] addr_b;
  logic [7:0] ctrl_view;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] rd_clear;

  // ----------------------------------------------------------------
  // Gate input synchroniser
  // ----------------------------------------------------------------
  level_sync #(
    .STAGES(SYNC_STAGES)
  ) u_gate_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(gate_in),
    .sync_out(gate_sync)
  );

  // ----------------------------------------------------------------
  // Gate signal path
  // ----------------------------------------------------------------
  // Active-level gate after polarity
  assign gate_level = cfg_r.gate_polarity ? gate_sync : ~gate_sync; // [RL8]
  assign lvl_rise = gate_level & ~lvl_prev_r;
  // Toggle flip-flop replaces the gate in toggle mode
  assign gate_src = cfg_r.gate_toggle_mode ? toggle_r : gate_level; // [RL1]
  assign src_rise = gate_src & ~src_prev_r;
  assign src_fall = ~gate_src & src_prev_r;
  // Single pulse lets through one active period only
  assign acquiring = (sp_r == SP_ACQUIRE);
  assign go_done = (sp_r != SP_IDLE); // [RL3] [RL4]
  assign gate_value = cfg_r.gate_single_pulse_mode ?
                      (gate_src & acquiring) : gate_src; // [RL2]
  assign pulse_done = acquiring & src_fall;

  // Edge history
  always_comb begin
    lvl_prev_nxt = gate_level;
    src_prev_nxt = gate_src;
  end

  // Toggle flip-flop next value
  always_comb begin
    toggle_nxt = toggle_r;
    if (!timer_on_r) begin
      toggle_nxt = 1'b0; // [RL7]
    end else if (!cfg_r.gate_toggle_mode) begin
      toggle_nxt = 1'b0; // [RL1]
    end else if (lvl_rise) begin
      toggle_nxt = ~toggle_r; // [RL1]
    end
  end

  // Count enable, gate ignored when gating is off
  always_comb begin
    count_nxt = 1'b0;
    if (timer_on_r) begin
      count_nxt = cfg_r.gate_enable ? gate_value : 1'b1; // [RL8]
    end
  end

  // ----------------------------------------------------------------
  // Single-pulse acquisition
  // ----------------------------------------------------------------
  always_comb begin
    sp_nxt = sp_r;
    case (sp_r)
      SP_IDLE: begin
        sp_nxt = SP_IDLE;
      end
      SP_ARMED: begin
        if (src_rise) begin
          sp_nxt = SP_ACQUIRE; // [RL3]
        end
      end
      SP_ACQUIRE: begin
        if (src_fall) begin
          sp_nxt = SP_IDLE; // [RL4]
        end
      end
      default: begin
        sp_nxt = SP_IDLE;
      end
    endcase
    // Software arming wins over a completion in the same cycle
    if (arm_req) begin
      sp_nxt = SP_ARMED; // [RL3]
    end
    if (!cfg_nxt.gate_single_pulse_mode) begin
      sp_nxt = SP_IDLE; // [RL5]
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign addr_b = 8'(paddr);
  assign access = psel & penable;
  assign done_xfer = access & pready_r;
  assign wr_ctrl = done_xfer & pwrite & (addr_b == ADDR_GATE_CTRL);
  assign arm_req = wr_ctrl & pwdata[BIT_GO_DONE] &
                   pwdata[BIT_SINGLE_PULSE];

  // Per-register strobes at the completing edge
  assign wr_timer_on = done_xfer & pwrite & (addr_b == ADDR_TIMER_ON);
  assign wr_mask = done_xfer & pwrite & (addr_b == ADDR_MASK);
  assign rd_status = done_xfer & ~pwrite & (addr_b == ADDR_STATUS);

  // Readable image of the gate control register
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[BIT_GATE_ENABLE] = cfg_r.gate_enable;
    ctrl_view[BIT_GATE_POLARITY] = cfg_r.gate_polarity;
    ctrl_view[BIT_TOGGLE_MODE] = cfg_r.gate_toggle_mode;
    ctrl_view[BIT_SINGLE_PULSE] = cfg_r.gate_single_pulse_mode;
    ctrl_view[BIT_GO_DONE] = go_done; // [RL3] [RL4]
    ctrl_view[BIT_GATE_VALUE] = gate_value; // [RL6]
  end

  // Ready one cycle into the access phase, read data latched with it
  always_comb begin
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    if (access && !pready_r) begin
      pready_nxt = 1'b1;
      prdata_nxt = RDATA_ZERO;
      if (addr_b == ADDR_GATE_CTRL) begin
        prdata_nxt = {24'h000000, ctrl_view};
      end else if (addr_b == ADDR_TIMER_ON) begin
        prdata_nxt[BIT_TIMER_ON] = timer_on_r;
      end else if (addr_b == ADDR_STATUS) begin
        prdata_nxt = 32'(status_r);
      end else if (addr_b == ADDR_MASK) begin
        prdata_nxt = 32'(mask_r);
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  // Register writes at the completing edge
  always_comb begin
    cfg_nxt = cfg_r;
    timer_on_nxt = timer_on_r;
    mask_nxt = mask_r;
    if (wr_ctrl) begin
      cfg_nxt.gate_enable = pwdata[BIT_GATE_ENABLE];
      cfg_nxt.gate_polarity = pwdata[BIT_GATE_POLARITY];
      cfg_nxt.gate_toggle_mode = pwdata[BIT_TOGGLE_MODE];
      cfg_nxt.gate_single_pulse_mode = pwdata[BIT_SINGLE_PULSE]; // [RL2]
    end
    if (wr_timer_on) begin
      timer_on_nxt = pwdata[BIT_TIMER_ON]; // [RL7]
    end
    if (wr_mask) begin
      mask_nxt = pwdata[EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    events = '0;
    events[EV_GATE_EDGE] = timer_on_r & src_rise;
    events[EV_PULSE_DONE] = pulse_done;
    rd_clear = '0;
    if (rd_status) begin
      rd_clear = prdata_r[EV_W-1:0];
    end
    // New events win over the read clear
    status_nxt = (status_r & ~rd_clear) | events;
    irq_nxt = |(status_nxt & mask_nxt);
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RESET;
      sp_r <= SP_IDLE;
      timer_on_r <= 1'b0;
      toggle_r <= 1'b0;
      // Active-low gate on a cleared sync reads high, so no false edge
      lvl_prev_r <= 1'b1;
      src_prev_r <= 1'b1;
      count_r <= 1'b0;
      irq_r <= 1'b0;
      status_r <= STATUS_RESET;
      mask_r <= MASK_RESET;
      prdata_r <= RDATA_ZERO;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      sp_r <= sp_nxt;
      timer_on_r <= timer_on_nxt;
      toggle_r <= toggle_nxt;
      lvl_prev_r <= lvl_prev_nxt;
      src_prev_r <= src_prev_nxt;
      count_r <= count_nxt;
      irq_r <= irq_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign count_enable = count_r;
  assign gate_flop = toggle_r;
  assign irq = irq_r;

endmodule : timer_gate_control

// ===== testbench/gate_source.sv
`timescale 1ns/100ps
// --------
// Gate source model
// --------
module gate_source (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic level_req, // Level asked
  output logic gate_in // Gate level
);
  // Level moves just after an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_in <= 1'b0;
    end else begin
      gate_in <= level_req;
    end
  end
endmodule : gate_source

// ===== testbench/timer_gate_control_checker.sv
`timescale 1ns/100ps
// --------
// Port checker
// --------
module timer_gate_control_checker
  import gate_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [ADDR_W-1:0] paddr, // Address
  input wire logic [31:0] pwdata, // Wdata
  input wire logic [31:0] prdata, // Rdata
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic gate_in, // Gate
  input wire logic count_enable, // Count
  input wire logic gate_flop, // Toggle ff
  input wire logic irq // Interrupt
);
  logic wr, ton_r, ton_nxt;
  logic [EV_W-1:0] msk_r, msk_nxt;
  gate_cfg_s cfg_r, cfg_nxt;

  // Shadow of written settings
  assign wr = psel && penable && pready && pwrite;
  always_comb begin
    ton_nxt = ton_r;
    cfg_nxt = cfg_r;
    msk_nxt = msk_r;
    if (wr && paddr == ADDR_TIMER_ON) ton_nxt = pwdata[BIT_TIMER_ON];
    if (wr && paddr == ADDR_GATE_CTRL) cfg_nxt = gate_cfg_s'(pwdata[7:4]);
    if (wr && paddr == ADDR_MASK) msk_nxt = pwdata[EV_W-1:0];
  end
  // Shadow registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ton_r <= 1'b0;
      cfg_r <= CFG_RESET;
      msk_r <= MASK_RESET;
    end else begin
      ton_r <= ton_nxt;
      cfg_r <= cfg_nxt;
      msk_r <= msk_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus and gate relations
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("late ready"); // one wait
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error"); // with ready
  property p_tgl; (!cfg_r.gate_toggle_mode) [*2] |-> !gate_flop; endproperty
  a_tgl: assert property (p_tgl) else $error("flop not clear");
  property p_off; (!ton_r) [*2] |-> !count_enable && !gate_flop; endproperty
  a_off: assert property (p_off) else $error("timer off active");
  property p_ung; (ton_r && !cfg_r.gate_enable) [*2] |-> count_enable;
  endproperty
  a_ung: assert property (p_ung) else $error("ungated stop");
  property p_gat;
    (ton_r && cfg_r.gate_enable && !cfg_r.gate_toggle_mode &&
     !cfg_r.gate_single_pulse_mode && $stable(cfg_r) && $stable(gate_in)) [*5]
    |-> count_enable == (gate_in == cfg_r.gate_polarity);
  endproperty
  a_gat: assert property (p_gat) else $error("gated count");
  property p_go;
    pready && !pwrite && paddr == ADDR_GATE_CTRL &&
    !cfg_r.gate_single_pulse_mode |-> !prdata[BIT_GO_DONE];
  endproperty
  a_go: assert property (p_go) else $error("go bit set");
  property p_irq; (msk_r == 2'h0) [*2] |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("masked irq"); // mask
endmodule : timer_gate_control_checker

bind timer_gate_control timer_gate_control_checker #(.ADDR_W(ADDR_W)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .gate_in(gate_in),
  .count_enable(count_enable), .gate_flop(gate_flop), .irq(irq));

// ===== testbench/timer_gate_control_tb.sv
`timescale 1ns/100ps
module timer_gate_control_tb;
  import gate_ctrl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic gate_in, count_enable, gate_flop, irq, level_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int bad_count, cmp_count;

  timer_gate_control timer_gate_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gate_in(gate_in),
    .count_enable(count_enable), .gate_flop(gate_flop), .irq(irq));
  gate_source gate_source_inst (.pclk(pclk), .presetn(presetn),
    .level_req(level_req), .gate_in(gate_in));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // --------
  // Tasks
  // --------
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  task automatic chk(input string s, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, string s);
    apb(1'b0, a, 32'h0);
    chk(s, rd, e);
  endtask : rchk

  task automatic gate(input logic v);
    level_req <= v;
    tick(8);
  endtask : gate

  task automatic stop_test;
    $display("Compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // Watchdog
  initial begin
    tick(4000);
    bad_count++;
    stop_test();
  end

  // --------
  // Main sequence
  // --------
  initial begin
    {presetn, psel, penable, pwrite, level_req} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tick(2);
    presetn <= 1'b1;
    // Low pin under active-low polarity shows an active gate
    rchk(ADDR_GATE_CTRL, 32'h4, "reset ctrl");
    for (int i = 1; i < 4; i++) rchk(8'(4 * i), 32'h0, "reset");
    rchk(8'h10, 32'h0, "unmapped");
    chk("slverr", 32'(er), 32'h1);
    // Timer on, ungated then gated
    apb(1'b1, ADDR_TIMER_ON, 32'h1);
    tick(3);
    chk("ungated", 32'(count_enable), 32'h1);
    apb(1'b1, ADDR_GATE_CTRL, 32'hC0);
    tick(3);
    chk("gate low", 32'(count_enable), 32'h0);
    gate(1'b1);
    chk("gate high", 32'(count_enable), 32'h1);
    rchk(ADDR_GATE_CTRL, 32'hC4, "value");
    apb(1'b1, ADDR_GATE_CTRL, 32'h40);
    rchk(ADDR_GATE_CTRL, 32'h44, "value no enable");
    apb(1'b1, ADDR_GATE_CTRL, 32'h80);
    tick(3);
    chk("low pol high", 32'(count_enable), 32'h0);
    gate(1'b0);
    chk("low pol low", 32'(count_enable), 32'h1);
    // Sticky events, mask and interrupt
    rchk(ADDR_STATUS, 32'h1, "edge event");
    rchk(ADDR_STATUS, 32'h0, "read cleared");
    apb(1'b1, ADDR_MASK, 32'h3);
    gate(1'b1);
    gate(1'b0);
    chk("irq", 32'(irq), 32'h1);
    rchk(ADDR_STATUS, 32'h1, "status");
    tick(2);
    chk("irq clear", 32'(irq), 32'h0);
    apb(1'b1, ADDR_MASK, 32'h0);
    gate(1'b1);
    gate(1'b0);
    chk("irq masked", 32'(irq), 32'h0);
    rchk(ADDR_STATUS, 32'h1, "masked sticky");
    // Toggle flip-flop
    apb(1'b1, ADDR_GATE_CTRL, 32'h60);
    for (int k = 0; k < 3; k++) begin
      gate(1'b0);
      gate(1'b1);
      chk("toggle", 32'(gate_flop), 32'((k + 1) % 2));
    end
    apb(1'b1, ADDR_GATE_CTRL, 32'h40);
    tick(3);
    chk("toggle off", 32'(gate_flop), 32'h0);
    apb(1'b1, ADDR_GATE_CTRL, 32'h60);
    gate(1'b0);
    gate(1'b1);
    apb(1'b1, ADDR_TIMER_ON, 32'h0);
    tick(3);
    chk("off flop", 32'(gate_flop), 32'h0);
    chk("off count", 32'(count_enable), 32'h0);
    // Single-pulse acquisition
    apb(1'b1, ADDR_TIMER_ON, 32'h1);
    gate(1'b0);
    apb(1'b1, ADDR_GATE_CTRL, 32'hD8);
    rchk(ADDR_GATE_CTRL, 32'hD8, "armed");
    chk("wait edge", 32'(count_enable), 32'h0);
    gate(1'b1);
    chk("acquire", 32'(count_enable), 32'h1);
    gate(1'b0);
    rchk(ADDR_GATE_CTRL, 32'hD0, "done");
    rchk(ADDR_STATUS, 32'h3, "done event");
    gate(1'b1);
    chk("one pulse", 32'(count_enable), 32'h0);
    gate(1'b0);
    apb(1'b1, ADDR_GATE_CTRL, 32'hD8);
    rchk(ADDR_GATE_CTRL, 32'hD8, "rearmed");
    apb(1'b1, ADDR_GATE_CTRL, 32'hC8);
    rchk(ADDR_GATE_CTRL, 32'hC0, "mode off");
    gate(1'b1);
    chk("normal", 32'(count_enable), 32'h1);
    stop_test();
  end
endmodule : timer_gate_control_tb
